// ===== logic/pfmeb_pin_mux.v
/*
  Pin-level logic of the external program/data bus, the multiplexed port E
  bits 2..7 and the ready/FIFO strobe pins.
  Assumes all core-side and pin inputs are synchronous to ref_clk and that the
  timer, serial, interrupt and interface engines sit outside this block.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pfmeb_map.vh"

module pfmeb_pin_mux (
  input  wire        ref_clk,
  input  wire        rst_n,
  // Core side of the external bus.
  input  wire [15:0] cpu_addr,
  input  wire        cpu_code_fetch,
  input  wire        cpu_bus_rd,
  input  wire        cpu_bus_wr,
  input  wire [7:0]  cpu_wdata,
  output reg  [7:0]  cpu_rdata,
  input  wire        suspend,
  input  wire        external_access_pin,
  // External bus pins.
  output reg  [15:0] ext_addr,
  output reg         code_fetch_strobe_n,
  input  wire [7:0]  ext_data_in,
  output reg  [7:0]  ext_data_out,
  output reg         ext_data_oe,
  // Port E configuration and general purpose side.
  input  wire [7:0]  porte_alt_config,
  input  wire [7:2]  porte_gpio_out,
  input  wire [7:2]  porte_gpio_dir,
  output reg  [7:2]  porte_gpio_in,
  // Alternate function sources and sinks.
  input  wire        timer2_overflow,
  input  wire [1:0]  serial0_mode,
  input  wire        serial0_sync,
  input  wire        serial0_sync_data,
  input  wire [1:0]  serial1_mode,
  input  wire        serial1_sync_data,
  input  wire        timer2_ext_enable,
  input  wire        iface_address_bit8,
  output reg         irq6_request,
  output reg         timer2_reload,
  // Port E pins.
  input  wire [7:2]  porte_pin_in,
  output reg  [7:2]  porte_pin_out,
  output reg  [7:2]  porte_pin_oe,
  // Ready pins and interface configuration.
  input  wire [1:0]  interface_config,
  input  wire [3:2]  fifo_pin_polarity,
  input  wire        ready_in0,
  input  wire        ready_in1,
  input  wire        ready_in2,
  output reg  [2:0]  engine_ready,
  output reg         fifo_read_strobe,
  output reg         fifo_write_strobe
);

  reg         fetch_hit;
  reg  [7:2]  next_pin_out;
  reg  [7:2]  next_pin_oe;
  wire        rd_level;
  wire        wr_level;
  wire        serial0_echo;
  wire        serial1_echo;
  wire        irq6_edge;
  wire        timer2_reload_input_edge;
  wire        alt_timer2_overflow_out;
  wire        alt_rxd0;
  wire        alt_rxd1;
  wire        alt_irq6;
  wire        alt_timer2_reload_input;
  wire        alt_adr8;
  wire        fifo_mode;
  wire        master_mode;

  assign alt_timer2_overflow_out   = porte_alt_config[`PFMEB_ALT_TIMER2_OVERFLOW_OUT];
  assign alt_rxd0    = porte_alt_config[`PFMEB_ALT_RXD0];
  assign alt_rxd1    = porte_alt_config[`PFMEB_ALT_RXD1];
  assign alt_irq6    = porte_alt_config[`PFMEB_ALT_IRQ6];
  assign alt_timer2_reload_input    = porte_alt_config[`PFMEB_ALT_TIMER2_RELOAD_INPUT];
  assign alt_adr8    = porte_alt_config[`PFMEB_ALT_ADR8];
  assign fifo_mode   = (interface_config == `PFMEB_MODE_FIFO);
  assign master_mode = (interface_config == `PFMEB_MODE_MASTER);

  pfmeb_echo_select i_pfmeb_echo_select_s0 (
    .mode      (serial0_mode),
    .sync      (serial0_sync),
    .sync_data (serial0_sync_data),
    .echo      (serial0_echo)
  );

  // Serial 1 echo level.
  // Serial port 1 reports no sync flag of its own, so mode 0 alone opens it.
  pfmeb_echo_select i_pfmeb_echo_select_s1 (
    .mode      (serial1_mode),
    .sync      (1'b1),
    .sync_data (serial1_sync_data),
    .echo      (serial1_echo)
  );

  always @* begin
    if (external_access_pin) begin
      fetch_hit = cpu_code_fetch;
    end else begin
      fetch_hit = cpu_code_fetch && (cpu_addr > `PFMEB_INT_ROM_TOP);
    end
  end

  always @* begin
    next_pin_out = porte_gpio_out;
    next_pin_oe  = porte_gpio_dir;
    if (alt_timer2_overflow_out) begin
      next_pin_out[`PFMEB_ALT_TIMER2_OVERFLOW_OUT] = timer2_overflow;
      next_pin_oe[`PFMEB_ALT_TIMER2_OVERFLOW_OUT]  = 1'b1;
    end
    if (alt_rxd0) begin
      next_pin_out[`PFMEB_ALT_RXD0] = serial0_echo;
      next_pin_oe[`PFMEB_ALT_RXD0]  = 1'b1;
    end
    if (alt_rxd1) begin
      next_pin_out[`PFMEB_ALT_RXD1] = serial1_echo;
      next_pin_oe[`PFMEB_ALT_RXD1]  = 1'b1;
    end
    // Input alternates release the pin so the outside can drive it.
    if (alt_irq6) begin
      next_pin_out[`PFMEB_ALT_IRQ6] = 1'b0;
      next_pin_oe[`PFMEB_ALT_IRQ6]  = 1'b0;
    end
    if (alt_timer2_reload_input) begin
      next_pin_out[`PFMEB_ALT_TIMER2_RELOAD_INPUT] = 1'b0;
      next_pin_oe[`PFMEB_ALT_TIMER2_RELOAD_INPUT]  = 1'b0;
    end
    if (alt_adr8) begin
      next_pin_out[`PFMEB_ALT_ADR8] = iface_address_bit8;
      next_pin_oe[`PFMEB_ALT_ADR8]  = 1'b1;
    end
  end

  pfmeb_strobe_level i_pfmeb_strobe_level_rd (
    .active_high (fifo_pin_polarity[`PFMEB_POL_RD]),
    .pin         (ready_in0),
    .level       (rd_level)
  );

  pfmeb_strobe_level i_pfmeb_strobe_level_wr (
    .active_high (fifo_pin_polarity[`PFMEB_POL_WR]),
    .pin         (ready_in1),
    .level       (wr_level)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_addr            <= `PFMEB_ADDR_RST;
      code_fetch_strobe_n <= 1'b1;
      ext_data_out        <= `PFMEB_DATA_RST;
      ext_data_oe         <= 1'b0;
      cpu_rdata           <= `PFMEB_DATA_RST;
    end else begin
      ext_addr            <= cpu_addr;
      code_fetch_strobe_n <= ~fetch_hit;
      if (suspend) begin
        ext_data_out <= `PFMEB_SUSPEND_DATA;
        ext_data_oe  <= 1'b1;
      end else begin
        ext_data_out <= cpu_wdata;
        ext_data_oe  <= cpu_bus_wr;
      end
      if (cpu_bus_rd && !cpu_bus_wr && !suspend) begin
        cpu_rdata <= ext_data_in;
      end
    end
  end

  pfmeb_edge_detect #(
    .RISING (1)
  ) i_pfmeb_edge_detect_irq6 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (porte_pin_in[`PFMEB_ALT_IRQ6]),
    .seen    (irq6_edge)
  );

  pfmeb_edge_detect #(
    .RISING (0)
  ) i_pfmeb_edge_detect_timer2_reload_input (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin     (porte_pin_in[`PFMEB_ALT_TIMER2_RELOAD_INPUT]),
    .seen    (timer2_reload_input_edge)
  );

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      porte_pin_out <= `PFMEB_PE_RST;
      porte_pin_oe  <= `PFMEB_PE_RST;
      porte_gpio_in <= `PFMEB_PE_RST;
      irq6_request  <= 1'b0;
      timer2_reload <= 1'b0;
    end else begin
      porte_pin_out <= next_pin_out;
      porte_pin_oe  <= next_pin_oe;
      porte_gpio_in <= porte_pin_in;
      irq6_request  <= alt_irq6 && irq6_edge;
      timer2_reload <= alt_timer2_reload_input && timer2_ext_enable && timer2_reload_input_edge;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      engine_ready      <= 3'h0;
      fifo_read_strobe  <= 1'b0;
      fifo_write_strobe <= 1'b0;
    end else begin
      engine_ready[0]   <= master_mode && ready_in0;
      engine_ready[1]   <= master_mode && ready_in1;
      engine_ready[2]   <= ready_in2;
      fifo_read_strobe  <= fifo_mode && rd_level;
      fifo_write_strobe <= fifo_mode && wr_level;
    end
  end

endmodule // pfmeb_pin_mux

// Echo level for a serial data pin: the synchronous data in mode 0 while the
// port runs in sync operation, a steady high at all other times.
module pfmeb_echo_select (
  input  wire [1:0] mode,
  input  wire       sync,
  input  wire       sync_data,
  output reg        echo
);

  always @* begin
    if ((mode == `PFMEB_SER_MODE0) && sync) begin
      echo = sync_data;
    end else begin
      // An idle high keeps an attached receiver in its mark state.
      echo = 1'b1;
    end
  end

endmodule // pfmeb_echo_select

// Active-high view of a strobe pin whose polarity is programmable.
module pfmeb_strobe_level (
  input  wire active_high,
  input  wire pin,
  output reg  level
);

  always @* begin
    if (active_high) begin
      level = pin;
    end else begin
      level = ~pin;
    end
  end

endmodule // pfmeb_strobe_level

// Edge finder on a pin that is already synchronous to ref_clk. The stored
// sample resets to the level that the wanted edge ends on, so a pin that sits
// at either level when reset lifts yields no false edge.
module pfmeb_edge_detect #(
  parameter RISING = 1
) (
  input  wire ref_clk,
  input  wire rst_n,
  input  wire pin,
  output reg  seen
);

  reg prev;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= (RISING != 0);
    end else begin
      prev <= pin;
    end
  end

  always @* begin
    if (RISING != 0) begin
      seen = pin && !prev;
    end else begin
      seen = !pin && prev;
    end
  end

endmodule // pfmeb_edge_detect

`default_nettype wire

// ===== logic/pfmeb_map.vh
/*
  Constants for the pin function multiplexer of the external bus and port E.
  Assumes it is included by bare name from the design file under logic/.
*/
`ifndef PFMEB_MAP_VH
`define PFMEB_MAP_VH

`define PFMEB_ADDR_W        16
`define PFMEB_DATA_W        8
`define PFMEB_INT_ROM_TOP   16'h3FFF
`define PFMEB_ADDR_RST      16'h0000
`define PFMEB_DATA_RST      8'h00
`define PFMEB_SUSPEND_DATA  8'h00

`define PFMEB_ALT_TIMER2_OVERFLOW_OUT     2
`define PFMEB_ALT_RXD0      3
`define PFMEB_ALT_RXD1      4
`define PFMEB_ALT_IRQ6      5
`define PFMEB_ALT_TIMER2_RELOAD_INPUT      6
`define PFMEB_ALT_ADR8      7
`define PFMEB_PE_RST        6'h00

`define PFMEB_POL_RD        3
`define PFMEB_POL_WR        2

`define PFMEB_MODE_PORT     2'h0
`define PFMEB_MODE_MASTER   2'h2
`define PFMEB_MODE_FIFO     2'h3
`define PFMEB_SER_MODE0     2'h0

`endif

// ===== tb/pfmeb_ext_mem.sv
/* External memory model on the data bus.
   Assumes a registered address bus and an active high drive enable. */
`timescale 1ns/1ps
`default_nettype none
module pfmeb_ext_mem (
  input  wire logic        ref_clk,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_data_oe,
  output wire logic [7:0]  ext_data_in
);
  logic [7:0] mem [16];
  always @(posedge ref_clk) if (ext_data_oe) mem[ext_addr[3:0]] <= ext_data_out;
  // Answer bus reads, echoing the bus while the device drives it.
  assign ext_data_in = ext_data_oe ? ext_data_out : mem[ext_addr[3:0]];
endmodule // pfmeb_ext_mem
`default_nettype wire

// ===== tb/pfmeb_pin_mux_checker.sv
/* Assertions on the pin multiplexer ports.
   Assumes a bind onto pfmeb_pin_mux with ports connected by name. */
`timescale 1ns/1ps
`default_nettype none
module pfmeb_pin_mux_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_code_fetch,
  input wire logic        cpu_bus_wr,
  input wire logic [7:0]  cpu_wdata,
  input wire logic        suspend,
  input wire logic        external_access_pin,
  input wire logic [15:0] ext_addr,
  input wire logic        code_fetch_strobe_n,
  input wire logic [7:0]  ext_data_out,
  input wire logic        ext_data_oe,
  input wire logic [7:0]  porte_alt_config,
  input wire logic        timer2_overflow,
  input wire logic        timer2_ext_enable,
  input wire logic [7:2]  porte_pin_in,
  input wire logic [7:2]  porte_pin_out,
  input wire logic [7:2]  porte_pin_oe,
  input wire logic        irq6_request,
  input wire logic        timer2_reload
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The first edge after reset still sees reset-time inputs, so it is skipped.
  a_addr_mirror: assert property ($past(rst_n) |->
    ext_addr == $past(cpu_addr)) else $error("address bus lost");
  a_fetch_range: assert property ($past(rst_n) |-> code_fetch_strobe_n !=
    $past(cpu_code_fetch && (external_access_pin || cpu_addr > 16'h3FFF)))
    else $error("fetch strobe wrong");
  a_write_drive: assert property ($past(rst_n && cpu_bus_wr && !suspend) |->
    ext_data_oe && ext_data_out == $past(cpu_wdata)) else $error("write data wrong");
  a_suspend_low: assert property ($past(rst_n && suspend) |->
    ext_data_oe && ext_data_out == 8'h00) else $error("suspend bus not low");
  a_reset_state: assert property (disable iff (1'b0) !rst_n |-> ext_addr == 16'h0000
    && code_fetch_strobe_n && !ext_data_oe && porte_pin_oe == 6'h00)
    else $error("reset pin state wrong");
  a_t2_pulse: assert property ($past(rst_n && porte_alt_config[2]) |->
    porte_pin_oe[2] && porte_pin_out[2] == $past(timer2_overflow)) else $error("t2 out wrong");
  a_irq6_edge: assert property ($past(rst_n) && $past(rst_n, 2) |-> irq6_request ==
    ($past(porte_alt_config[5] && porte_pin_in[5]) && !$past(porte_pin_in[5], 2)))
    else $error("irq6 edge wrong");
  a_reload_edge: assert property ($past(rst_n) && $past(rst_n, 2) |-> timer2_reload ==
    ($past(porte_alt_config[6] && timer2_ext_enable && !porte_pin_in[6])
    && $past(porte_pin_in[6], 2))) else $error("reload edge wrong");
endmodule // pfmeb_pin_mux_checker
`default_nettype wire

// ===== tb/pfmeb_pin_mux_tb.sv
/* Self-checking bench for the pin multiplexer.
   Assumes the design, checker and memory model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pfmeb_pin_mux_tb;
  // The clock opens high so that reset falls on a real edge after time zero.
  logic ref_clk = 1'b1, rst_n = 1'b1;
  logic [15:0] cpu_addr, ext_addr;
  logic [7:0] cpu_wdata, cpu_rdata, ext_data_in, ext_data_out, porte_alt_config;
  logic cpu_code_fetch, cpu_bus_rd, cpu_bus_wr, suspend, external_access_pin;
  logic code_fetch_strobe_n, ext_data_oe, timer2_overflow, serial0_sync;
  logic serial0_sync_data, serial1_sync_data, timer2_ext_enable, iface_address_bit8;
  logic irq6_request, timer2_reload, ready_in0, ready_in1, ready_in2;
  logic fifo_read_strobe, fifo_write_strobe;
  logic [7:2] porte_gpio_out, porte_gpio_dir, porte_gpio_in;
  logic [7:2] porte_pin_in, porte_pin_out, porte_pin_oe;
  logic [1:0] serial0_mode, serial1_mode, interface_config;
  logic [3:2] fifo_pin_polarity;
  logic [2:0] engine_ready;
  int bad_count = 0, compares = 0;
  // Rows: expected strobe, access pin, fetch, address.
  logic [18:0] rows [5] = '{19'h53FFF, 19'h14000, 19'h30000, 19'h6FFFF, 19'h1FFFF};
  always #5 ref_clk = ~ref_clk;
  pfmeb_pin_mux i_pfmeb_pin_mux (.*);
  pfmeb_ext_mem i_pfmeb_ext_mem (.*);
  task chk(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task step;
    @(negedge ref_clk);
  endtask
  task rst_chk;
    chk(ext_addr, 16'h0000);
    chk({code_fetch_strobe_n, ext_data_oe, porte_pin_oe}, 16'h0080);
  endtask
  task close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {cpu_code_fetch, cpu_bus_rd, cpu_bus_wr, cpu_wdata, suspend, external_access_pin} = '0;
    {porte_alt_config, porte_gpio_out, timer2_overflow, serial0_mode, serial0_sync} = '0;
    {serial0_sync_data, serial1_mode, serial1_sync_data, timer2_ext_enable} = '0;
    {iface_address_bit8, porte_pin_in, interface_config, fifo_pin_polarity} = '0;
    {ready_in0, ready_in1, ready_in2} = 3'h1;
    cpu_addr = 16'hA5A5;
    porte_gpio_dir = 6'h3F;
    step;
    rst_n = 1'b0;
    step;
    rst_chk;
    repeat (2) step;
    rst_n = 1'b1;
    foreach (rows[i]) begin
      {external_access_pin, cpu_code_fetch, cpu_addr} = rows[i][17:0];
      step;
      chk(code_fetch_strobe_n, rows[i][18]);
      chk(ext_addr, cpu_addr);
    end
    {cpu_code_fetch, cpu_bus_wr, cpu_addr, cpu_wdata} = {2'h1, 16'h0003, 8'h5A};
    step;
    chk({ext_data_oe, ext_data_out}, 16'h015A);
    {cpu_bus_wr, cpu_bus_rd} = 2'h1;
    repeat (2) step;
    chk(cpu_rdata, 16'h005A);
    {cpu_bus_rd, suspend} = 2'h1;
    step;
    chk({ext_data_oe, ext_data_out}, 16'h0100);
    suspend = 1'b0;
    {porte_alt_config, timer2_overflow, serial0_sync, iface_address_bit8} = {8'hFC, 3'h7};
    serial1_sync_data = 1'b1;
    step;
    chk({porte_pin_out[7], porte_pin_out[4:2], porte_pin_oe}, 16'h0367);
    timer2_overflow = 1'b0;
    for (int m = 1; m < 4; m++) begin
      {serial0_mode, serial1_mode} = {m[1:0], m[1:0]};
      step;
      chk(porte_pin_out[4:2], 16'h0006);
    end
    {serial0_mode, serial0_sync} = 3'h0;
    step;
    chk(porte_pin_out[3], 16'h0001);
    porte_pin_in[5] = 1'b1;
    step;
    chk(irq6_request, 16'h0001);
    step;
    chk(irq6_request, 16'h0000);
    for (int e = 0; e < 2; e++) begin
      timer2_ext_enable = e[0];
      porte_pin_in[6] = 1'b1;
      step;
      porte_pin_in[6] = 1'b0;
      step;
      chk(timer2_reload, e[0]);
    end
    {porte_alt_config, porte_gpio_dir, porte_gpio_out, porte_pin_in} = {8'h00, 18'h0F16A};
    step;
    chk({porte_pin_oe, porte_pin_out[5:2], porte_gpio_in}, 16'h3D6A);
    rst_n = 1'b0;
    step;
    rst_chk;
    rst_n = 1'b1;
    {interface_config, ready_in0} = 3'h7;
    for (int p = 0; p < 4; p++) begin
      fifo_pin_polarity = p[1:0];
      step;
      chk({engine_ready, fifo_read_strobe, fifo_write_strobe}, {3'h4, p[1], ~p[0]});
    end
    interface_config = 2'h2;
    step;
    chk({engine_ready, fifo_read_strobe, fifo_write_strobe}, 16'h0014);
    interface_config = 2'h0;
    step;
    chk({engine_ready, fifo_read_strobe, fifo_write_strobe}, 16'h0010);
    close_out;
  end
endmodule // pfmeb_pin_mux_tb
bind pfmeb_pin_mux pfmeb_pin_mux_checker i_pfmeb_pin_mux_checker (.*);
`default_nettype wire
